// ===== verilog/nhb_pkg.sv
// Constants, opcodes and operation plans for the NAND host bus controller.
// Assumes a single 200 MHz clock and an asynchronous multiplexed NAND part.
package nhb_pkg;

   localparam int CLK_PERIOD_PS = 5000;

   // Least times round up to whole clock cycles, never below one
   function automatic int cyc_min(input int t_ns);
      int c;
      c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min

   localparam int T_SETUP_NS = 10;
   localparam int T_WP_NS    = 12;
   localparam int T_WH_NS    = 10;
   // Read low phase covers access time plus the two-flop input sampler
   localparam int T_RP_NS    = 30;
   localparam int T_REH_NS   = 10;
   localparam int T_WB_NS    = 100;
   localparam int T_WHR_NS   = 60;

   localparam int SETUP_CYC = cyc_min(T_SETUP_NS);
   localparam int WP_CYC    = cyc_min(T_WP_NS);
   localparam int WH_CYC    = cyc_min(T_WH_NS);
   localparam int RP_CYC    = cyc_min(T_RP_NS);
   localparam int REH_CYC   = cyc_min(T_REH_NS);
   localparam int WB_CYC    = cyc_min(T_WB_NS);
   localparam int WHR_CYC   = cyc_min(T_WHR_NS);

   localparam logic [7:0] OPC_READ_1     = 8'h00;
   localparam logic [7:0] OPC_READ_2     = 8'h30;
   localparam logic [7:0] OPC_CB_READ_2  = 8'h35;
   localparam logic [7:0] OPC_READ_ID    = 8'h90;
   localparam logic [7:0] OPC_RESET      = 8'hff;
   localparam logic [7:0] OPC_PROG_1     = 8'h80;
   localparam logic [7:0] OPC_PROG_2     = 8'h10;
   localparam logic [7:0] OPC_CPROG_2    = 8'h15;
   localparam logic [7:0] OPC_CB_PROG_1  = 8'h85;
   localparam logic [7:0] OPC_ERASE_1    = 8'h60;
   localparam logic [7:0] OPC_ERASE_2    = 8'hd0;
   localparam logic [7:0] OPC_STATUS     = 8'h70;
   localparam logic [7:0] OPC_STATUS_ENH = 8'h78;
   localparam logic [7:0] OPC_STATUS_EXT = 8'hf2;
   localparam logic [7:0] OPC_RND_OUT_1  = 8'h05;
   localparam logic [7:0] OPC_RND_OUT_2  = 8'he0;
   localparam logic [7:0] OPC_CACHE_SEQ  = 8'h31;
   localparam logic [7:0] OPC_CACHE_END  = 8'h3f;
   localparam logic [7:0] OPC_PARAM      = 8'hec;

   // Address layout: column width per organisation and cycle masks
   localparam int         COL_BITS_X8  = 13;
   localparam int         COL_BITS_X16 = 12;
   localparam logic [7:0] COL_HI_X8    = 8'h1f;
   localparam logic [7:0] COL_HI_X16   = 8'h0f;
   localparam logic [7:0] ROW_TOP_MASK = 8'h03;
   localparam logic [2:0] ADDR_CYCLES  = 3'h5;
   localparam logic [2:0] COL_CYCLES   = 3'h2;
   localparam logic [2:0] ROW_CYCLES   = 3'h3;

   typedef enum logic [4:0] {
      OP_PAGE_READ, OP_CB_READ, OP_READ_ID, OP_RESET, OP_PAGE_PROG, OP_CACHE_PROG,
      OP_CB_PROG, OP_ERASE, OP_STATUS, OP_STATUS_ENH, OP_STATUS_EXT, OP_RND_IN,
      OP_RND_OUT, OP_CACHE_SEQ, OP_CACHE_RND, OP_CACHE_END, OP_PARAM
   } nhb_op_t;

   typedef struct packed {
      logic [7:0] cmd1;
      logic [2:0] addr_n;
      logic [2:0] addr_first;
      logic       din;
      logic       cmd2_en;
      logic [7:0] cmd2;
      logic       wait_rdy;
      logic       dout;
      logic       modify;
   } nhb_plan_t;

   function automatic nhb_plan_t mk(input logic [7:0] c1, input logic [2:0] an,
                                    input logic [2:0] af, input logic di, input logic c2e,
                                    input logic [7:0] c2, input logic wr, input logic d_o,
                                    input logic md);
      nhb_plan_t p;
      p = '{c1, an, af, di, c2e, c2, wr, d_o, md};
      return p;
   endfunction : mk

   // Cycle sequence of each operation
   function automatic nhb_plan_t plan_of(input nhb_op_t op);
      nhb_plan_t p;
      p = mk(OPC_STATUS, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
      case (op)
         OP_PAGE_READ:  p = mk(OPC_READ_1, ADDR_CYCLES, 3'h0, 1'b0, 1'b1, OPC_READ_2,
                               1'b1, 1'b1, 1'b0); // Always opens with 00h
         OP_CB_READ:    p = mk(OPC_READ_1, ADDR_CYCLES, 3'h0, 1'b0, 1'b1, OPC_CB_READ_2,
                               1'b1, 1'b0, 1'b0);
         OP_READ_ID:    p = mk(OPC_READ_ID, 3'h1, 3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
         OP_RESET:      p = mk(OPC_RESET, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0);
         OP_PAGE_PROG:  p = mk(OPC_PROG_1, ADDR_CYCLES, 3'h0, 1'b1, 1'b1, OPC_PROG_2,
                               1'b1, 1'b0, 1'b1);
         OP_CACHE_PROG: p = mk(OPC_PROG_1, ADDR_CYCLES, 3'h0, 1'b1, 1'b1, OPC_CPROG_2,
                               1'b1, 1'b0, 1'b1);
         OP_CB_PROG:    p = mk(OPC_CB_PROG_1, ADDR_CYCLES, 3'h0, 1'b1, 1'b1, OPC_PROG_2,
                               1'b1, 1'b0, 1'b1);
         OP_ERASE:      p = mk(OPC_ERASE_1, ROW_CYCLES, COL_CYCLES, 1'b0, 1'b1, OPC_ERASE_2,
                               1'b1, 1'b0, 1'b1);
         OP_STATUS:     p = mk(OPC_STATUS, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
         OP_STATUS_ENH: p = mk(OPC_STATUS_ENH, ROW_CYCLES, COL_CYCLES, 1'b0, 1'b0, 8'h00,
                               1'b0, 1'b1, 1'b0);
         OP_STATUS_EXT: p = mk(OPC_STATUS_EXT, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
         OP_RND_IN:     p = mk(OPC_CB_PROG_1, COL_CYCLES, 3'h0, 1'b1, 1'b0, 8'h00,
                               1'b0, 1'b0, 1'b0);
         OP_RND_OUT:    p = mk(OPC_RND_OUT_1, COL_CYCLES, 3'h0, 1'b0, 1'b1, OPC_RND_OUT_2,
                               1'b0, 1'b1, 1'b0);
         OP_CACHE_SEQ:  p = mk(OPC_CACHE_SEQ, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0);
         OP_CACHE_RND:  p = mk(OPC_READ_1, ADDR_CYCLES, 3'h0, 1'b0, 1'b1, OPC_CACHE_SEQ,
                               1'b1, 1'b1, 1'b0);
         OP_CACHE_END:  p = mk(OPC_CACHE_END, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0);
         OP_PARAM:      p = mk(OPC_PARAM, 3'h1, 3'h0, 1'b0, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0);
         default:       p = mk(OPC_STATUS, 3'h0, 3'h0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0);
      endcase
      return p;
   endfunction : plan_of

   // One address byte per index
   function automatic logic [7:0] addr_byte(input logic word_wide, input logic [2:0] idx,
                                            input logic [30:0] a);
      logic [30:0] row;
      row = word_wide ? (a >> COL_BITS_X16) : (a >> COL_BITS_X8);
      case (idx)
         3'h0:    return a[7:0];
         3'h1:    return a[15:8] & (word_wide ? COL_HI_X16 : COL_HI_X8);
         3'h2:    return row[7:0];
         3'h3:    return row[15:8];
         default: return row[23:16] & ROW_TOP_MASK;
      endcase
   endfunction : addr_byte

endpackage : nhb_pkg

// ===== verilog/nhb_pin_cycle.sv
// One write or read strobe cycle on the NAND pins: setup, low, high phases.
// Assumes the caller holds CLE, ALE and DQ steady from start to done.
`timescale 1ns/1ps
module nhb_pin_cycle #(
   parameter int DQ_W = 8
) (
   input  wire logic            ref_clk,
   input  wire logic            reset_n,
   input  wire logic            start,
   input  wire logic            is_read,
   input  wire logic [DQ_W-1:0] bus_in,
   output logic                 we_n,
   output logic                 re_n,
   output logic                 idle,
   output logic                 done,
   output logic [DQ_W-1:0]      rd_word
);
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_LOW, PH_HIGH} nhb_phase_t;

   nhb_phase_t phase;
   logic [7:0] cnt;
   logic       rd;

   wire last      = (cnt == 8'h01);
   wire [7:0] low_len  = rd ? 8'(nhb_pkg::RP_CYC) : 8'(nhb_pkg::WP_CYC);
   wire [7:0] high_len = rd ? 8'(nhb_pkg::REH_CYC) : 8'(nhb_pkg::WH_CYC);
   assign idle    = (phase == PH_IDLE);
   assign done    = (phase == PH_HIGH) && last;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         phase <= PH_IDLE;
         cnt   <= 8'h00;
         rd    <= 1'b0;
      end else begin
         unique case (phase)
            PH_IDLE: if (start) begin
               phase <= PH_SETUP;
               cnt   <= 8'(nhb_pkg::SETUP_CYC);
               rd    <= is_read;
            end
            PH_SETUP: if (last) begin
               phase <= PH_LOW;
               cnt   <= low_len;
            end else cnt <= cnt - 8'h01;
            PH_LOW: if (last) begin
               phase <= PH_HIGH;
               cnt   <= high_len;
            end else cnt <= cnt - 8'h01;
            PH_HIGH: if (last) phase <= PH_IDLE;
               else cnt <= cnt - 8'h01;
         endcase
      end
   end

   // Strobes from flops so they never glitch; the device latches on the WE rise
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         we_n    <= 1'b1;
         re_n    <= 1'b1;
         rd_word <= '0;
      end else begin
         we_n <= !((phase == PH_SETUP && last && !rd) || (phase == PH_LOW && !last && !rd));
         re_n <= !((phase == PH_SETUP && last && rd) || (phase == PH_LOW && !last && rd));
         if (phase == PH_LOW && last && rd) rd_word <= bus_in;
      end
   end

   property p_we_low_len;
      @(posedge ref_clk) disable iff (!reset_n)
         $fell(we_n) |-> (!we_n)[*3] ##1 we_n;
   endproperty
   a_we_low_len: assert property (p_we_low_len) else $error("write strobe low time wrong");

   property p_re_low_len;
      @(posedge ref_clk) disable iff (!reset_n)
         $fell(re_n) |-> (!re_n)[*6] ##1 re_n;
   endproperty
   a_re_low_len: assert property (p_re_low_len) else $error("read strobe low time wrong");

   property p_one_strobe;
      @(posedge ref_clk) disable iff (!reset_n)
         !(!we_n && !re_n);
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
endmodule : nhb_pin_cycle

// ===== verilog/nhb_host_ctrl.sv
// Host-side NAND sequencer: turns one operation request into command,
// address, data and ready-wait cycles on the asynchronous NAND pins.
// Assumes one device on the bus; DQ and ready line arrive unsynchronised.
`timescale 1ns/1ps
module nhb_host_ctrl #(
   parameter int DQ_W = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             req_valid,
   output logic                  req_ready,
   input  wire nhb_pkg::nhb_op_t req_op,
   input  wire logic [30:0]      req_addr,
   input  wire logic [15:0]      req_len,
   input  wire logic             protect,
   input  wire logic [DQ_W-1:0]  wr_data,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   output logic [DQ_W-1:0]       rd_data,
   output logic                  rd_valid,
   output logic                  op_done,
   output logic                  ce_n,
   output logic                  cle,
   output logic                  ale,
   output logic                  we_n,
   output logic                  re_n,
   output logic                  wp_n,
   input  wire logic [DQ_W-1:0]  dq_in,
   output logic [DQ_W-1:0]       dq_out,
   output logic                  dq_oe,
   input  wire logic             rb_n
);
   if (DQ_W != 8 && DQ_W != 16) begin : g_bad_width
      $error("DQ_W must be 8 or 16");
   end

   localparam logic WORD_WIDE = (DQ_W == 16);

   typedef enum logic [3:0] {
      ST_IDLE, ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2, ST_WB, ST_BUSY, ST_GAP, ST_DOUT, ST_DONE
   } nhb_state_t;

   nhb_state_t        state;
   nhb_state_t        next_state;
   nhb_pkg::nhb_op_t  op;
   nhb_pkg::nhb_plan_t plan;
   logic [30:0]       addr;
   logic [15:0]       left;
   logic [2:0]        aidx;
   logic [2:0]        acnt;
   logic [7:0]        wcnt;
   logic [DQ_W-1:0]   dq_s1;
   logic [DQ_W-1:0]   dq_s2;
   logic              rb_s1;
   logic              rb_s2;
   logic              pin_idle;
   logic              pin_done;
   logic [DQ_W-1:0]   pin_word;

   assign plan = nhb_pkg::plan_of(op);

   // Pins from outside pass two flops before anything reads them
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         dq_s1 <= '0;
         dq_s2 <= '0;
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
      end else begin
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         rb_s1 <= rb_n;
         rb_s2 <= rb_s1;
      end
   end

   wire is_cmd    = (state == ST_CMD1) || (state == ST_CMD2);
   wire beat_st   = is_cmd || (state == ST_ADDR) || (state == ST_DOUT) ||
                    ((state == ST_DIN) && wr_valid);
   wire pin_start = beat_st && pin_idle;
   wire dev_ready = rb_s2;
   wire wait_done = (wcnt == 8'h01);

   assign req_ready = (state == ST_IDLE);
   assign wr_ready  = (state == ST_DIN) && pin_idle;

   // Where to go once the address phase (or its absence) is over
   wire nhb_state_t after_wait = plan.dout ? ST_GAP : ST_DONE;
   wire nhb_state_t after_cmd2 = plan.wait_rdy ? ST_WB : after_wait;
   wire nhb_state_t after_din  = plan.cmd2_en ? ST_CMD2 : ST_DONE;
   wire nhb_state_t after_addr = (plan.din && left != 16'h0000) ? ST_DIN :
                                 plan.din ? after_din :
                                 plan.cmd2_en ? ST_CMD2 : after_cmd2;

   // Never issue a new opcode until the ready line has come back
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (req_valid) next_state = ST_CMD1;
         ST_CMD1: if (pin_done) next_state = (plan.addr_n != 3'h0) ? ST_ADDR : after_addr;
         ST_ADDR: if (pin_done && acnt == 3'h1) next_state = after_addr;
         ST_DIN:  if (pin_done && left == 16'h0001) next_state = after_din;
         ST_CMD2: if (pin_done) next_state = after_cmd2;
         ST_WB:   if (wait_done) next_state = ST_BUSY;
         ST_BUSY: if (dev_ready) next_state = after_wait;
         ST_GAP:  if (wait_done) next_state = (left != 16'h0000) ? ST_DOUT : ST_DONE;
         ST_DOUT: if (pin_done && left == 16'h0001) next_state = ST_DONE;
         ST_DONE: next_state = ST_IDLE;
      endcase
   end

   wire take = (state == ST_IDLE) && req_valid;
   wire [15:0] next_left = (pin_done && (state == ST_DIN || state == ST_DOUT)) ?
                           left - 16'h0001 : left;
   wire [7:0]  next_wcnt = (next_state == ST_WB && state != ST_WB) ? 8'(nhb_pkg::WB_CYC) :
                           (next_state == ST_GAP && state != ST_GAP) ? 8'(nhb_pkg::WHR_CYC) :
                           (wcnt != 8'h00) ? wcnt - 8'h01 : wcnt;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         op    <= nhb_pkg::OP_STATUS;
         addr  <= '0;
         left  <= 16'h0000;
         wcnt  <= 8'h00;
      end else begin
         state <= next_state;
         wcnt  <= next_wcnt;
         if (take) begin
            op   <= req_op;
            addr <= req_addr;
            left <= req_len;
         end else left <= next_left;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         aidx <= 3'h0;
         acnt <= 3'h0;
      end else if (state == ST_CMD1) begin
         aidx <= plan.addr_first;
         acnt <= plan.addr_n;
      end else if (state == ST_ADDR && pin_done) begin
         aidx <= aidx + 3'h1;
         acnt <= acnt - 3'h1;
      end
   end

   // Opcodes and address bytes ride the low lane, upper lane zero
   wire [7:0]      cmd_byte = (state == ST_CMD2) ? plan.cmd2 : plan.cmd1;
   wire [7:0]      adr_byte = nhb_pkg::addr_byte(WORD_WIDE, aidx, addr);
   wire [DQ_W-1:0] drive    = (state == ST_DIN) ? wr_data :
                              DQ_W'(is_cmd ? cmd_byte : adr_byte);

   // Latch enables never both high: CLE for opcodes, ALE for address
   // Output phase keeps both low and CE low with WE idle high
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ce_n     <= 1'b1;
         cle      <= 1'b0;
         ale      <= 1'b0;
         dq_oe    <= 1'b0;
         dq_out   <= '0;
         wp_n     <= 1'b0;
         rd_data  <= '0;
         rd_valid <= 1'b0;
         op_done  <= 1'b0;
      end else begin
         ce_n     <= (next_state == ST_IDLE) || (state == ST_DONE);
         cle      <= (next_state == ST_CMD1) || (next_state == ST_CMD2);
         ale      <= (next_state == ST_ADDR);
         dq_oe    <= (state == ST_CMD1 || state == ST_ADDR || state == ST_DIN ||
                      state == ST_CMD2) && !(pin_done && next_state != state);
         if (pin_start) dq_out <= drive;
         // Modify operations hold protect off until done
         wp_n     <= (state != ST_IDLE && plan.modify) ? 1'b1 : !protect;
         rd_valid <= (state == ST_DOUT) && pin_done;
         if ((state == ST_DOUT) && pin_done) rd_data <= pin_word;
         op_done  <= (state == ST_DONE);
      end
   end

   nhb_pin_cycle #(.DQ_W(DQ_W)) u_pin (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .start   (pin_start),
      .is_read (state == ST_DOUT),
      .bus_in  (dq_s2),
      .we_n    (we_n),
      .re_n    (re_n),
      .idle    (pin_idle),
      .done    (pin_done),
      .rd_word (pin_word)
   );

   sequence s_cmd_latch;
      cle && !ale && !we_n;
   endsequence
   property p_latch_excl;
      @(posedge ref_clk) disable iff (!reset_n) !we_n |-> !(cle && ale) && !ce_n;
   endproperty
   a_latch_excl: assert property (p_latch_excl) else $error("both latches high");

   property p_cmd_low_lane;
      @(posedge ref_clk) disable iff (!reset_n)
         s_cmd_latch |-> (dq_out >> 8) == '0 && dq_oe;
   endproperty
   a_cmd_low_lane: assert property (p_cmd_low_lane) else $error("opcode not on low lane");

   property p_read_pins;
      @(posedge ref_clk) disable iff (!reset_n)
         !re_n |-> !cle && !ale && we_n && !ce_n && !dq_oe;
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("bad pin state during read");

   property p_wp_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         (state == ST_BUSY && plan.modify) |-> wp_n;
   endproperty
   a_wp_hold: assert property (p_wp_hold) else $error("protect dropped while busy");

   property p_busy_hold;
      @(posedge ref_clk) disable iff (!reset_n)
         (state == ST_BUSY && !dev_ready) |=> state == ST_BUSY && we_n;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("left busy wait early");

   property p_prog_close;
      @(posedge ref_clk) disable iff (!reset_n)
         (s_cmd_latch and (dq_out[7:0] == nhb_pkg::OPC_PROG_2 ||
          dq_out[7:0] == nhb_pkg::OPC_CPROG_2)) |->
         (plan.cmd1 == nhb_pkg::OPC_PROG_1 || plan.cmd1 == nhb_pkg::OPC_CB_PROG_1);
   endproperty
   a_prog_close: assert property (p_prog_close) else $error("program close without open");

   property p_addr2_mask;
      @(posedge ref_clk) disable iff (!reset_n)
         (ale && !we_n && aidx == 3'h1) |->
         (dq_out[7:0] & ~(WORD_WIDE ? nhb_pkg::COL_HI_X16 : nhb_pkg::COL_HI_X8)) == 8'h00;
   endproperty
   a_addr2_mask: assert property (p_addr2_mask) else $error("column high byte not masked");

   property p_wb_wait;
      @(posedge ref_clk) disable iff (!reset_n)
         (state == ST_CMD2 && next_state == ST_WB) |=> (state == ST_WB)[*8];
   endproperty
   a_wb_wait: assert property (p_wb_wait) else $error("busy sampled too soon");

   property p_rd_after_strobe;
      @(posedge ref_clk) disable iff (!reset_n)
         rd_valid |-> $past(re_n, 3) == 1'b0 && re_n;
   endproperty
   a_rd_after_strobe: assert property (p_rd_after_strobe) else $error("word without strobe");
endmodule : nhb_host_ctrl

// ===== tb/nhb_flash_model.sv
// Behavioural byte-wide NAND device on the far side of the host sequencer.
// Assumes the bench resolves DQ and puts the pull-up on the ready line.
`timescale 1ns/1ps
module nhb_flash_model #(
   parameter int BUSY_CYC = 40
) (
   input  wire logic       ref_clk,
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       re_n,
   input  wire logic       wp_n,
   input  wire logic [7:0] dq,
   output logic [7:0]      dq_val,
   output logic            rb_pull
);
   logic [7:0] cmds[$];
   logic [7:0] addrs[$];
   logic [7:0] dins[$];
   logic [7:0] data = 8'h00;
   int         busy = 0;
   int         refused = 0;
   // A released bus shows the inverse of the last word, never a held value
   assign dq_val  = (!ce_n && !re_n) ? data : ~data;
   assign rb_pull = busy > 0;
   always @(posedge we_n) if (!ce_n) begin
      if (cle && !ale) begin
         cmds.push_back(dq);
         if (busy == 0 && dq inside {8'h30, 8'h35, 8'h31, 8'h3f, 8'hec, 8'hff}) busy = BUSY_CYC;
         if (busy == 0 && dq inside {8'h10, 8'h15, 8'hd0}) begin
            if (wp_n) busy = BUSY_CYC;
            else refused++;
         end
      end else if (ale && !cle) begin
         if (addrs.size() == 0) data = dq - 8'h01;
         addrs.push_back(dq);
      end else if (!cle && !ale) dins.push_back(dq);
   end
   // Column steps by one on each read strobe fall; read mode needs no command
   always @(negedge re_n) if (!ce_n && !cle && !ale) data = data + 8'h01;
   // Busy runs down even while deselected
   always @(posedge ref_clk) if (busy > 0) busy <= busy - 1;
endmodule : nhb_flash_model

// ===== tb/nhb_host_ctrl_test.sv
// Self-checking bench for the NAND host sequencer against a device model.
// Assumes a byte-wide bus, a pull-up on the ready line and a 200 MHz clock.
`timescale 1ns/1ps
module nhb_host_ctrl_test;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
   logic             ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, protect = 1'b1;
   logic             wr_valid = 1'b0, req_ready, rd_valid, op_done, wr_ready, rb_pull, rb_n;
   logic             ce_n, cle, ale, we_n, re_n, wp_n, dq_oe;
   nhb_pkg::nhb_op_t req_op = nhb_pkg::OP_STATUS;
   logic [30:0]      req_addr = 31'h0, a = 31'h6d5be9f3;
   logic [15:0]      req_len = 16'h0;
   logic [7:0]       wr_data = 8'h00, rd_data, dq_out, dq_in, dq_val;
   logic [7:0]       rd_q[$], wr_q[$];
   int               miscompares = 0, checks_done = 0, cycles = 0;
   assign dq_in = dq_oe ? dq_out : dq_val;
   assign rb_n  = !rb_pull;
   nhb_host_ctrl #(.DQ_W(8)) u_nhb_host_ctrl (.ref_clk, .reset_n, .req_valid, .req_ready,
      .req_op, .req_addr, .req_len, .protect, .wr_data, .wr_valid, .wr_ready, .rd_data,
      .rd_valid, .op_done, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .dq_in, .dq_out, .dq_oe,
      .rb_n);
   nhb_flash_model u_nhb_flash_model (.ref_clk, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n,
      .dq(dq_in), .dq_val, .rb_pull);
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic run_op(input nhb_pkg::nhb_op_t op, input int n);
      int   i;
      logic rtake, wtake, fin;
      i   = 0;
      fin = 1'b0;
      rd_q.delete();
      u_nhb_flash_model.cmds.delete();
      u_nhb_flash_model.addrs.delete();
      u_nhb_flash_model.dins.delete();
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_op    <= op;
      req_addr  <= a;
      req_len   <= 16'(n);
      wr_valid  <= 1'b1;
      wr_data   <= wr_q.size() > 0 ? wr_q[0] : 8'h00;
      // Outputs are read mid-cycle, away from the edge that launches them
      while (!fin) begin
         @(negedge ref_clk);
         rtake = req_valid && (req_ready === 1'b1);
         wtake = (wr_ready === 1'b1);
         fin   = (op_done === 1'b1);
         if (rd_valid === 1'b1) rd_q.push_back(rd_data);
         @(posedge ref_clk);
         if (rtake) req_valid <= 1'b0;
         if (wtake) begin
            i++;
            wr_data <= i < wr_q.size() ? wr_q[i] : 8'h00;
         end
      end
      wr_valid <= 1'b0;
   endtask : run_op
   task automatic t_reset();
      `CHK({ce_n, cle, ale, we_n, re_n, wp_n, dq_oe, req_ready}, 8'h99)
   endtask : t_reset
   task automatic t_read();
      logic [7:0] ex[5];
      logic [7:0] ew[5];
      ex = '{a[7:0], {3'h0, a[12:8]}, a[20:13], a[28:21], {6'h0, a[30:29]}};
      ew = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20], {6'h0, a[29:28]}};
      for (int k = 0; k < 5; k++) `CHK(nhb_pkg::addr_byte(1'b1, 3'(k), a), ew[k])
      run_op(nhb_pkg::OP_PAGE_READ, 3);
      `CHK(rb_pull, 1'b0)
      `CHK(u_nhb_flash_model.cmds[0], 8'h00)
      `CHK(u_nhb_flash_model.cmds[1], 8'h30)
      for (int k = 0; k < 5; k++) `CHK(u_nhb_flash_model.addrs[k], ex[k])
      `CHK(rd_q.size(), 3)
      for (int k = 0; k < 3; k++) `CHK(rd_q[k], a[7:0] + 8'(k))
   endtask : t_read
   task automatic t_prog();
      wr_q = '{8'h5a, 8'hc3};
      run_op(nhb_pkg::OP_PAGE_PROG, 2);
      `CHK(u_nhb_flash_model.cmds[0], 8'h80)
      `CHK(u_nhb_flash_model.cmds[1], 8'h10)
      `CHK(u_nhb_flash_model.dins[0], 8'h5a)
      `CHK(u_nhb_flash_model.dins[1], 8'hc3)
      `CHK(u_nhb_flash_model.refused, 0)
      repeat (2) @(posedge ref_clk);
      `CHK(wp_n, 1'b0)
   endtask : t_prog
   task automatic t_table();
      nhb_pkg::nhb_op_t ops[15];
      logic [15:0]      cc[15];
      ops = '{nhb_pkg::OP_CB_READ, nhb_pkg::OP_READ_ID, nhb_pkg::OP_RESET,
         nhb_pkg::OP_CACHE_PROG, nhb_pkg::OP_CB_PROG, nhb_pkg::OP_ERASE, nhb_pkg::OP_STATUS,
         nhb_pkg::OP_STATUS_ENH, nhb_pkg::OP_STATUS_EXT, nhb_pkg::OP_RND_IN,
         nhb_pkg::OP_RND_OUT, nhb_pkg::OP_CACHE_SEQ, nhb_pkg::OP_CACHE_RND,
         nhb_pkg::OP_CACHE_END, nhb_pkg::OP_PARAM};
      cc = '{16'h0035, 16'h9090, 16'hffff, 16'h8015, 16'h8510, 16'h60d0, 16'h7070, 16'h7878,
         16'hf2f2, 16'h8585, 16'h05e0, 16'h3131, 16'h0031, 16'h3f3f, 16'hecec};
      wr_q = '{8'h96};
      for (int k = 0; k < 15; k++) begin
         run_op(ops[k], 1);
         `CHK(u_nhb_flash_model.cmds[0], cc[k][15:8])
         `CHK(u_nhb_flash_model.cmds[$], cc[k][7:0])
      end
   endtask : t_table
   initial begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_read();
      t_prog();
      t_table();
      summarize();
   end
endmodule : nhb_host_ctrl_test
